// [pwm_core_params.svh]
// register offsets, field positions and reset values of the pwm core
`ifndef PWM_CORE_PARAMS_SVH
`define PWM_CORE_PARAMS_SVH
`define A_POLCLK 8'h41
`define A_ENABLE 8'h42
`define A_SCALE0 8'h44
`define A_SCNT0 8'h45
`define A_SCALE1 8'h46
`define A_SCNT1 8'h47
`define A_CNT_GRP 6'h12
`define A_PER_GRP 6'h13
`define A_DTY_GRP 6'h14
`define A_CTL 8'h54
`define A_TST 8'h55
`define A_PDATA 8'h56
`define A_PDIR 8'h57
`define CTL_WAIT 4
`define CTL_CENTER 3
`define CTL_RDRV 2
`define CTL_PUP 1
`define CTL_BGSTOP 0
`define TST_CRDIS 2
`define TST_PCDIS 1
`define TST_SLDIS 0
`define TST_RST 3'h0
`define REG_RST 8'h00
`define PIN_OFF 8'hFF
`define CNT_ZERO 8'h00
`define CNT_ONE 8'h01
`define DUTY_FULL 8'hFF
`endif

// [pwm_core_pkg.sv]
// shared types of the pwm core
package pwm_core_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic [1:0] {
        DIR_UP = 2'b01,
        DIR_DOWN = 2'b10
    } dir_t;
endpackage

// [pwm_chan_if.sv]
// link between the register side and one channel counter
`timescale 1ns/10ps
`default_nettype none
interface pwm_chan_if;
    logic tick;
    logic en;
    logic center;
    logic pol;
    logic period_hold;
    logic cnt_clear;
    logic cnt_wr;
    pwm_core_pkg::byte_t per;
    pwm_core_pkg::byte_t dty;
    pwm_core_pkg::byte_t cnt;
    logic out;
    modport core (output tick, en, center, pol, period_hold, cnt_clear, cnt_wr, per, dty,
        input cnt, out);
    modport chan (input tick, en, center, pol, period_hold, cnt_clear, cnt_wr, per, dty,
        output cnt, out);
endinterface
`default_nettype wire

// [pwm_channel_unit.sv]
// one 8-bit pwm channel: counter, working compare values and output level
`timescale 1ns/10ps
`default_nettype none
`include "pwm_core_params.svh"
module pwm_channel_unit (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // link to the register side
    pwm_chan_if.chan ch
);
    import pwm_core_pkg::*;
    byte_t cnt_q;
    byte_t per_q;
    byte_t dty_q;
    dir_t dir_q;
    logic out_q;
    logic lvl;
    logic at_per;
    logic roll;
    logic step;

    assign step = ch.tick && ch.en;
    assign at_per = (cnt_q == per_q);
    // end of a period: left at period match, center on the way back through zero
    assign roll = step && (ch.center ? (dir_q == DIR_DOWN && cnt_q == `CNT_ZERO)
        : (at_per && !ch.period_hold));
    assign ch.cnt = cnt_q;
    assign ch.out = out_q;

    // counter: only advances on the selected clock while enabled
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            cnt_q <= `CNT_ZERO;
            dir_q <= DIR_UP;
        end else if (ch.cnt_clear) begin
            cnt_q <= `CNT_ZERO;
            dir_q <= DIR_UP;
        end else if (step) begin
            // left mode always counts up, whatever direction a center run left behind
            case (ch.center ? dir_q : DIR_UP)
                DIR_UP: begin
                    if (ch.center && at_per) begin
                        dir_q <= DIR_DOWN;
                        cnt_q <= (cnt_q == `CNT_ZERO) ? `CNT_ZERO : cnt_q - `CNT_ONE;
                    end else if (!ch.center && at_per && !ch.period_hold) begin
                        cnt_q <= `CNT_ZERO;
                    end else begin
                        cnt_q <= cnt_q + `CNT_ONE;
                    end
                end
                DIR_DOWN: begin
                    if (cnt_q == `CNT_ZERO) begin
                        dir_q <= DIR_UP;
                        cnt_q <= (per_q == `CNT_ZERO) ? `CNT_ZERO : `CNT_ONE;
                    end else begin
                        cnt_q <= cnt_q - `CNT_ONE;
                    end
                end
                default: dir_q <= DIR_UP;
            endcase
        end
    end

    // working values follow the written ones only at safe moments
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            per_q <= `REG_RST;
            dty_q <= `REG_RST;
        end else if (!ch.en || ch.cnt_wr || roll) begin
            per_q <= ch.per;
            dty_q <= ch.dty;
        end
    end

    // level form of the duty toggle; boundary cases take priority
    always_comb begin
        if (per_q == `CNT_ZERO) begin
            lvl = ch.pol;
        end else if (dty_q == `DUTY_FULL) begin
            lvl = !ch.pol;
        end else if (dty_q >= per_q) begin
            lvl = ch.pol;
        end else if (ch.center) begin
            // the duty value itself counts once, on the way down, for twice duty
            lvl = (cnt_q < dty_q || (dir_q == DIR_DOWN && cnt_q == dty_q
                && dty_q != `CNT_ZERO)) ? ch.pol : !ch.pol;
        end else begin
            lvl = (cnt_q <= dty_q) ? ch.pol : !ch.pol;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            out_q <= 1'b0;
        end else begin
            out_q <= lvl;
        end
    end

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    a_count_clear: assert property (ch.cnt_clear |=> cnt_q == `CNT_ZERO)
        else $error("counter not cleared by write");
    a_idle_count: assert property (!ch.en && !ch.cnt_clear |=> $stable(cnt_q))
        else $error("disabled counter moved");
    a_left_restart: assert property (step && !ch.center && at_per && !ch.period_hold
        && !ch.cnt_clear |=> cnt_q == `CNT_ZERO)
        else $error("left period match did not restart");
    a_period_hold: assert property (step && !ch.center && at_per && ch.period_hold
        && !ch.cnt_clear |=> cnt_q == $past(cnt_q) + `CNT_ONE)
        else $error("held period match reset counter");
    a_buffer_keep: assert property (ch.en && !roll && !ch.cnt_wr |=> $stable(per_q)
        && $stable(dty_q))
        else $error("working value changed mid period");
    a_full_duty: assert property (per_q != `CNT_ZERO && dty_q == `DUTY_FULL
        |=> out_q == !$past(ch.pol))
        else $error("full duty level wrong");
endmodule
`default_nettype wire

// [pwm_channel_core.sv]
// four-channel 8-bit pwm core with register port and shared general-purpose port
`timescale 1ns/10ps
`default_nettype none
`include "pwm_core_params.svh"
module pwm_channel_core (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // register port
    input wire logic [7:0] reg_addr_in,
    input wire pwm_core_pkg::byte_t reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output pwm_core_pkg::byte_t reg_rdata_out,
    // part modes and prescaled clock pulses
    input wire logic normal_mode_flag_in,
    input wire logic wait_mode_in,
    input wire logic background_mode_in,
    input wire logic clk_a_tick_in,
    input wire logic clk_b_tick_in,
    // shared general-purpose port
    input wire logic [7:0] port_pin_in,
    output logic [7:0] port_pin_out,
    output logic [7:0] port_pin_oe_n_out,
    output logic port_pullup_enable_out,
    output logic port_reduced_drive_out
);
    import pwm_core_pkg::*;
    localparam int CH_NUM = 4;

    byte_t scale_q [2];
    byte_t scnt_q [2];
    logic [1:0] half_q;
    logic [1:0] src_tick;
    logic [1:0] scaled_tick;
    byte_t per_q [CH_NUM];
    byte_t dty_q [CH_NUM];
    byte_t polclk_q;
    logic [CH_NUM-1:0] en_q;
    byte_t ctl_q;
    logic [2:0] tst_q;
    byte_t pdata_q;
    byte_t pdir_q;
    byte_t rdata_q;
    byte_t rd_mux;
    byte_t pin_s1_q;
    byte_t pin_s2_q;
    byte_t pin_s3_q;
    byte_t pin_lvl_q;
    byte_t pin_out_q;
    byte_t pin_oe_n_q;
    byte_t pwm_lvl;
    byte_t pwm_own;
    byte_t chan_cnt [CH_NUM];
    logic [CH_NUM-1:0] cnt_wr;
    logic run;
    logic special;
    logic [1:0] ch_idx;
    logic grp_cnt;
    logic grp_per;
    logic grp_dty;

    assign special = !normal_mode_flag_in;
    assign ch_idx = reg_addr_in[1:0];
    assign grp_cnt = (reg_addr_in[7:2] == `A_CNT_GRP);
    assign grp_per = (reg_addr_in[7:2] == `A_PER_GRP);
    assign grp_dty = (reg_addr_in[7:2] == `A_DTY_GRP);

    // clock generation stops in wait or background mode only when asked to
    assign run = !(ctl_q[`CTL_WAIT] && wait_mode_in)
        && !(ctl_q[`CTL_BGSTOP] && background_mode_in);
    assign src_tick[0] = clk_a_tick_in && run;
    assign src_tick[1] = clk_b_tick_in && run;

    // scaled clock edge every second reload: value plus one, then by two
    assign scaled_tick[0] = src_tick[0] && (scnt_q[0] == `CNT_ZERO) && half_q[0];
    assign scaled_tick[1] = src_tick[1] && (scnt_q[1] == `CNT_ZERO) && half_q[1];

    // scale values
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            scale_q[0] <= `REG_RST;
            scale_q[1] <= `REG_RST;
        end else if (reg_wr_in && reg_addr_in == `A_SCALE0) begin
            scale_q[0] <= reg_wdata_in;
        end else if (reg_wr_in && reg_addr_in == `A_SCALE1) begin
            scale_q[1] <= reg_wdata_in;
        end
    end

    // scale down-counters; a write loads at once unless load is disabled
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            scnt_q[0] <= `CNT_ZERO;
            scnt_q[1] <= `CNT_ZERO;
            half_q <= 2'h0;
        end else begin
            for (int k = 0; k < 2; k++) begin
                if (reg_wr_in && reg_addr_in == (k == 0 ? `A_SCALE0 : `A_SCALE1)
                    && !(special && tst_q[`TST_SLDIS])) begin
                    scnt_q[k] <= reg_wdata_in;
                end else if (src_tick[k]) begin
                    if (scnt_q[k] == `CNT_ZERO) begin
                        scnt_q[k] <= scale_q[k];
                        half_q[k] <= !half_q[k];
                    end else begin
                        scnt_q[k] <= scnt_q[k] - `CNT_ONE;
                    end
                end
            end
        end
    end

    // written period and duty values; reads return these, not working copies
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < CH_NUM; i++) begin
                per_q[i] <= `REG_RST;
                dty_q[i] <= `REG_RST;
            end
        end else if (reg_wr_in && grp_per) begin
            per_q[ch_idx] <= reg_wdata_in;
        end else if (reg_wr_in && grp_dty) begin
            dty_q[ch_idx] <= reg_wdata_in;
        end
    end

    // clock select and polarity, channel enables, general control
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            polclk_q <= `REG_RST;
            en_q <= 4'h0;
            ctl_q <= `REG_RST;
        end else if (reg_wr_in) begin
            case (reg_addr_in)
                `A_POLCLK: polclk_q <= reg_wdata_in;
                `A_ENABLE: en_q <= reg_wdata_in[3:0];
                `A_CTL: ctl_q <= {3'h0, reg_wdata_in[4:0]};
                default: polclk_q <= polclk_q;
            endcase
        end
    end

    // test disables: special mode only, forced clear in normal mode
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            tst_q <= `TST_RST;
        end else if (!special) begin
            tst_q <= `TST_RST;
        end else if (reg_wr_in && reg_addr_in == `A_TST) begin
            tst_q <= reg_wdata_in[2:0];
        end
    end

    // counter write strobes per channel
    always_comb begin
        for (int i = 0; i < CH_NUM; i++) begin
            cnt_wr[i] = reg_wr_in && grp_cnt && (ch_idx == i[1:0]);
        end
    end

    // channels; a counter write is expected only while the channel is off
    pwm_chan_if chan_bus [CH_NUM] ();
    generate
        for (genvar i = 0; i < CH_NUM; i++) begin : g_ch
            if (i < 2) begin : g_a
                assign chan_bus[i].tick = polclk_q[4 + i] ? scaled_tick[0] : src_tick[0];
            end else begin : g_b
                assign chan_bus[i].tick = polclk_q[4 + i] ? scaled_tick[1] : src_tick[1];
            end
            assign chan_bus[i].en = en_q[i];
            assign chan_bus[i].center = ctl_q[`CTL_CENTER];
            assign chan_bus[i].pol = polclk_q[i];
            assign chan_bus[i].period_hold = special && tst_q[`TST_PCDIS];
            assign chan_bus[i].cnt_wr = cnt_wr[i];
            assign chan_bus[i].cnt_clear = cnt_wr[i] && !(special && tst_q[`TST_CRDIS]);
            assign chan_bus[i].per = per_q[i];
            assign chan_bus[i].dty = dty_q[i];
            assign chan_cnt[i] = chan_bus[i].cnt;
            assign pwm_lvl[i] = chan_bus[i].out;
            assign pwm_own[i] = en_q[i];
            pwm_channel_unit u_ch (
                .sys_clk_in(sys_clk_in),
                .rst_n_in(rst_n_in),
                .ch(chan_bus[i])
            );
        end
    endgenerate
    assign pwm_lvl[7:4] = 4'h0;
    assign pwm_own[7:4] = 4'h0;

    // port data latch and direction
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            pdata_q <= `REG_RST;
            pdir_q <= `REG_RST;
        end else if (reg_wr_in && reg_addr_in == `A_PDATA) begin
            pdata_q <= reg_wdata_in;
        end else if (reg_wr_in && reg_addr_in == `A_PDIR) begin
            pdir_q <= reg_wdata_in;
        end
    end

    // pin inputs: three stages, a change counts once stages two and three agree
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            pin_s1_q <= `REG_RST;
            pin_s2_q <= `REG_RST;
            pin_s3_q <= `REG_RST;
            pin_lvl_q <= `REG_RST;
        end else begin
            pin_s1_q <= port_pin_in;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            for (int b = 0; b < 8; b++) begin
                if (pin_s2_q[b] == pin_s3_q[b]) begin
                    pin_lvl_q[b] <= pin_s3_q[b];
                end
            end
        end
    end

    // pin drive: enabled channels win over the latch and force output
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            pin_out_q <= `REG_RST;
            pin_oe_n_q <= `PIN_OFF;
        end else begin
            pin_out_q <= (pwm_own & pwm_lvl) | (~pwm_own & pdata_q);
            pin_oe_n_q <= ~(pwm_own | pdir_q);
        end
    end
    assign port_pin_out = pin_out_q;
    assign port_pin_oe_n_out = pin_oe_n_q;
    assign port_pullup_enable_out = ctl_q[`CTL_PUP];
    assign port_reduced_drive_out = ctl_q[`CTL_RDRV];

    // read decode; reads have no side effects anywhere
    always_comb begin
        rd_mux = `REG_RST;
        if (grp_cnt) begin
            rd_mux = chan_cnt[ch_idx];
        end else if (grp_per) begin
            rd_mux = per_q[ch_idx];
        end else if (grp_dty) begin
            rd_mux = dty_q[ch_idx];
        end else begin
            case (reg_addr_in)
                `A_POLCLK: rd_mux = polclk_q;
                `A_ENABLE: rd_mux = {4'h0, en_q};
                `A_SCALE0: rd_mux = scale_q[0];
                `A_SCNT0: rd_mux = scnt_q[0];
                `A_SCALE1: rd_mux = scale_q[1];
                `A_SCNT1: rd_mux = scnt_q[1];
                `A_CTL: rd_mux = ctl_q;
                `A_TST: rd_mux = {5'h00, tst_q};
                `A_PDATA: rd_mux = (pdir_q & pdata_q) | (~pdir_q & pin_lvl_q);
                `A_PDIR: rd_mux = pdir_q;
                default: rd_mux = `REG_RST;
            endcase
        end
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            rdata_q <= `REG_RST;
        end else begin
            rdata_q <= reg_rd_in ? rd_mux : `REG_RST;
        end
    end
    assign reg_rdata_out = rdata_q;

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_scale1_at_zero;
        src_tick[1] && scnt_q[1] == `CNT_ZERO;
    endsequence
    sequence s_no_scale1_write;
        !(reg_wr_in && reg_addr_in == `A_SCALE1);
    endsequence
    a_scale_reload: assert property (s_scale1_at_zero and s_no_scale1_write
        |=> scnt_q[1] == $past(scale_q[1]))
        else $error("scale counter did not reload");
    a_scale_write: assert property (reg_wr_in && reg_addr_in == `A_SCALE1
        && !(special && tst_q[`TST_SLDIS]) |=> scnt_q[1] == $past(reg_wdata_in))
        else $error("scale write did not load counter");
    a_test_normal: assert property (!special |=> tst_q == `TST_RST)
        else $error("test bits set in normal mode");
    a_pin_forced: assert property (en_q[0] |=> !port_pin_oe_n_out[0])
        else $error("enabled channel pin not driven");
    a_halt_wait: assert property (ctl_q[`CTL_WAIT] && wait_mode_in |-> src_tick == 2'h0)
        else $error("clock ran while halted in wait");
    a_read_data: assert property (reg_rd_in && reg_addr_in == `A_PDIR
        |=> reg_rdata_out == $past(pdir_q))
        else $error("read data wrong");
    a_read_idle: assert property (!reg_rd_in |=> reg_rdata_out == `REG_RST)
        else $error("read data did not return to zero");
    a_port_drive: assert property (!en_q[1] && pdir_q[1]
        |=> port_pin_out[1] == $past(pdata_q[1]) && !port_pin_oe_n_out[1])
        else $error("free output pin not driven from latch");
endmodule
`default_nettype wire

// [pwm_pin_load.sv]
// external loads and drivers on the shared port pins
`timescale 1ns/10ps
`default_nettype none
module pwm_pin_load (
    // pin side of the core
    input wire logic [7:0] port_pin_out_in,
    input wire logic [7:0] port_pin_oe_n_in,
    input wire logic port_pullup_enable_in,
    input wire logic port_reduced_drive_in,
    // level that the outside world applies to free pins
    input wire logic [7:0] ext_level_in,
    // resolved pin levels
    output logic [7:0] pin_level_out
);
    // a driven pin follows the core; a free pin sees the pullup or the outside source
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!port_pin_oe_n_in[i]) begin
                pin_level_out[i] = port_pin_out_in[i];
            end else if (port_pullup_enable_in) begin
                pin_level_out[i] = 1'b1;
            end else begin
                pin_level_out[i] = ext_level_in[i];
            end
        end
    end
endmodule
`default_nettype wire

// [testbench.sv]
// self-checking bench for the four-channel pwm core
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import pwm_core_pkg::*;
    logic sys_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [7:0] reg_addr_in = 8'h00;
    byte_t reg_wdata_in = 8'h00;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    byte_t reg_rdata_out;
    logic normal_mode_flag_in = 1'b1;
    logic wait_mode_in = 1'b0;
    logic background_mode_in = 1'b0;
    logic clk_a_tick_in = 1'b0;
    logic clk_b_tick_in = 1'b0;
    logic [7:0] port_pin_in;
    logic [7:0] port_pin_out;
    logic [7:0] port_pin_oe_n_out;
    logic port_pullup_enable_out;
    logic port_reduced_drive_out;
    logic [7:0] ext_level = 8'hA5;
    int fail_count = 0;
    int samples_checked = 0;
    int hi_cnt;
    byte_t rd_val;
    byte_t rd_prev;
    // period, duty, polarity/clock, control, expected high cycles out of 48
    logic [39:0] cases [10] = '{40'h03_00_01_00_0C, 40'h03_00_00_00_24, 40'h03_FF_01_00_00,
        40'h03_FF_00_00_30, 40'h00_05_01_00_30, 40'h00_05_00_00_00, 40'h03_03_01_00_30,
        40'h03_03_00_00_00, 40'h03_01_01_08_10, 40'h03_01_00_08_20};

    pwm_channel_core u_pwm_channel_core (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
        .normal_mode_flag_in(normal_mode_flag_in), .wait_mode_in(wait_mode_in),
        .background_mode_in(background_mode_in), .clk_a_tick_in(clk_a_tick_in),
        .clk_b_tick_in(clk_b_tick_in), .port_pin_in(port_pin_in), .port_pin_out(port_pin_out),
        .port_pin_oe_n_out(port_pin_oe_n_out), .port_pullup_enable_out(port_pullup_enable_out),
        .port_reduced_drive_out(port_reduced_drive_out));
    pwm_pin_load u_pwm_pin_load (.port_pin_out_in(port_pin_out),
        .port_pin_oe_n_in(port_pin_oe_n_out), .port_pullup_enable_in(port_pullup_enable_out),
        .port_reduced_drive_in(port_reduced_drive_out), .ext_level_in(ext_level),
        .pin_level_out(port_pin_in));

    // 100 MHz clock
    always #5 sys_clk_in = ~sys_clk_in;

    task automatic chk(input string what, input byte_t seen, input byte_t exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one-cycle write strobe, released at the next edge
    task automatic wr(input logic [7:0] a, input byte_t d);
        @(posedge sys_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge sys_clk_in);
        reg_wr_in <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output byte_t d);
        @(posedge sys_clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge sys_clk_in);
        reg_rd_in <= 1'b0;
        #1 d = reg_rdata_out;
    endtask
    task automatic rchk(input string what, input logic [7:0] a, input byte_t exp);
        rd(a, rd_val);
        chk(what, rd_val, exp);
    endtask
    // both prescaled clocks pulse on n consecutive edges, then stop
    task automatic ticks(input int n);
        @(posedge sys_clk_in);
        clk_a_tick_in <= 1'b1;
        clk_b_tick_in <= 1'b1;
        repeat (n) @(posedge sys_clk_in);
        clk_a_tick_in <= 1'b0;
        clk_b_tick_in <= 1'b0;
        repeat (3) @(posedge sys_clk_in);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // hang guard
    initial begin
        repeat (20000) @(posedge sys_clk_in);
        fail_count++;
        results;
    end

    initial begin
        repeat (4) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        @(posedge sys_clk_in);
        #1 chk("pin enables after reset", port_pin_oe_n_out, 8'hFF);
        chk("pin levels after reset", port_pin_out, 8'h00);
        rchk("period0 after reset", 8'h4C, 8'h00);
        rchk("unmapped read", 8'h60, 8'h00);
        // waveform shapes with both clocks running every cycle
        @(posedge sys_clk_in);
        clk_a_tick_in <= 1'b1;
        clk_b_tick_in <= 1'b1;
        foreach (cases[i]) begin
            wr(8'h42, 8'h00);
            wr(8'h4C, cases[i][39:32]);
            wr(8'h50, cases[i][31:24]);
            wr(8'h41, cases[i][23:16]);
            wr(8'h54, cases[i][15:8]);
            wr(8'h48, 8'h00);
            wr(8'h42, 8'h01);
            rchk("period0 readback", 8'h4C, cases[i][39:32]);
            rchk("duty0 readback", 8'h50, cases[i][31:24]);
            repeat (2) @(posedge sys_clk_in);
            hi_cnt = 0;
            repeat (48) begin
                @(posedge sys_clk_in);
                #1 hi_cnt += (port_pin_out[0] === 1'b1);
            end
            chk("ch0 high cycles", hi_cnt[7:0], cases[i][7:0]);
        end
        // clock gating in wait and background modes
        wr(8'h54, 8'h19);
        @(posedge sys_clk_in);
        wait_mode_in <= 1'b1;
        repeat (3) @(posedge sys_clk_in);
        rd(8'h48, rd_prev);
        repeat (5) @(posedge sys_clk_in);
        rchk("count held in wait", 8'h48, rd_prev);
        @(posedge sys_clk_in);
        wait_mode_in <= 1'b0;
        background_mode_in <= 1'b1;
        repeat (3) @(posedge sys_clk_in);
        rd(8'h48, rd_prev);
        repeat (5) @(posedge sys_clk_in);
        rchk("count held in background", 8'h48, rd_prev);
        @(posedge sys_clk_in);
        background_mode_in <= 1'b0;
        clk_a_tick_in <= 1'b0;
        clk_b_tick_in <= 1'b0;
        // test-disable bits and special mode
        wr(8'h42, 8'h00);
        wr(8'h54, 8'h00);
        wr(8'h55, 8'h07);
        rchk("test reg write in normal", 8'h55, 8'h00);
        @(posedge sys_clk_in);
        normal_mode_flag_in <= 1'b0;
        wr(8'h55, 8'hFF);
        rchk("test reg in special", 8'h55, 8'h07);
        rd(8'h48, rd_prev);
        wr(8'h48, 8'h00);
        rchk("count kept on write", 8'h48, rd_prev);
        wr(8'h55, 8'h02);
        wr(8'h48, 8'h5A);
        rchk("count cleared on write", 8'h48, 8'h00);
        wr(8'h42, 8'h01);
        ticks(6);
        rchk("count past period", 8'h48, 8'h06);
        wr(8'h42, 8'h00);
        normal_mode_flag_in <= 1'b0;
        repeat (2) @(posedge sys_clk_in);
        normal_mode_flag_in <= 1'b1;
        repeat (2) @(posedge sys_clk_in);
        rchk("test reg forced in normal", 8'h55, 8'h00);
        // second scaler and channel 2 clock choice
        wr(8'h42, 8'h04);
        wr(8'h46, 8'h05);
        rchk("scale1 counter load", 8'h47, 8'h05);
        ticks(2);
        rchk("scale1 count down", 8'h47, 8'h03);
        ticks(4);
        rchk("scale1 reload at zero", 8'h47, 8'h05);
        @(posedge sys_clk_in);
        normal_mode_flag_in <= 1'b0;
        wr(8'h55, 8'h01);
        wr(8'h46, 8'h09);
        rchk("scale1 load disabled", 8'h47, 8'h05);
        rchk("scale1 value", 8'h46, 8'h09);
        wr(8'h55, 8'h00);
        normal_mode_flag_in <= 1'b1;
        wr(8'h46, 8'h01);
        wr(8'h41, 8'h40);
        wr(8'h4E, 8'hFF);
        wr(8'h4A, 8'h00);
        ticks(16);
        rchk("ch2 on scaled clock", 8'h4A, 8'h04);
        wr(8'h41, 8'h00);
        wr(8'h4A, 8'h00);
        ticks(8);
        rchk("ch2 on clock b", 8'h4A, 8'h08);
        // shared port: latch, pin reads and channel override
        wr(8'h42, 8'h00);
        wr(8'h57, 8'h02);
        wr(8'h56, 8'hF2);
        repeat (5) @(posedge sys_clk_in);
        #1 chk("pin enables", port_pin_oe_n_out, 8'hFD);
        chk("pin drive", port_pin_out & 8'h02, 8'h02);
        rchk("port data read", 8'h56, 8'hA7);
        wr(8'h42, 8'h01);
        repeat (3) @(posedge sys_clk_in);
        #1 chk("pin enables with ch0", port_pin_oe_n_out, 8'hFC);
        rchk("direction kept", 8'h57, 8'h02);
        wr(8'h44, 8'h02);
        rchk("scale0 counter load", 8'h45, 8'h02);
        // pullups lift every free pin; bit 0 belongs to the running channel
        wr(8'h54, 8'h06);
        #1 rd_val = {6'h00, port_pullup_enable_out, port_reduced_drive_out};
        chk("pullup and drive", rd_val, 8'h03);
        repeat (4) @(posedge sys_clk_in);
        rd(8'h56, rd_val);
        chk("port read with pullups", rd_val | 8'h01, 8'hFF);
        results;
    end
endmodule
`default_nettype wire
